// ===== dv/pht_core_bench.sv
// self-checking bench for the hazard and delayed-register control
`timescale 1ns/1ns
`include "pht_map.vh"
module pht_core_bench;
  logic pclk, presetn, psel, penable, pwrite, iss_valid, iss_imm_one;
  logic trap_take;
  logic [7:0] paddr, iss_ra, iss_rb, iss_rc;
  logic [31:0] pwdata;
  logic [3:0] iss_op;
  logic [15:0] iss_imm;
  wire [31:0] prdata, out_imm_r, out_carry_r, out_gr1_r;
  wire pready, pslverr, iss_ready, out_valid_r, out_xlat_r, intr_ok;
  wire [3:0] out_op_r, out_byte_lane_r;
  wire [7:0] out_abs_a_r, out_abs_b_r, out_abs_c_r, out_count_r;
  wire [1:0] out_half_lane_r, out_ps_r;
  wire [2:0] fp_done_r, fp_busy;
  int n_errors = 0;
  int n_checks = 0;
  int no = 0;
  int b, st, i;
  logic [31:0] rd;
  logic er;
  logic [2:0] dsn = 3'h0;
  logic [74:0] lg [0:63];
  logic [3:0] ops [0:5];

  pht_core #(.DIV_LAT(4)) i_pht_core (.*);

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // log each result; reads at the edge see pre-edge values
  always @(posedge pclk) begin
    dsn <= dsn | fp_done_r;
    if (out_valid_r === 1'b1) begin
      lg[no] = {out_abs_a_r, out_gr1_r, out_imm_r, out_ps_r, out_xlat_r};
      no = no + 1;
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h want %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    if (n_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: a hang is ended by the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // called on an edge; holds the offer until taken or 51 stalls pass, st counts stalls
  task iss(input logic [3:0] op, input logic [7:0] a, input logic [7:0] c,
      input logic [15:0] im, input logic one, input logic tr);
    st = 0;
    iss_valid <= 1'b1;
    iss_op <= op;
    iss_ra <= a;
    iss_rb <= c;
    iss_rc <= c;
    iss_imm <= im;
    iss_imm_one <= one;
    trap_take <= tr;
    // ready read at the edge is the value that decides the take
    forever begin
      @(posedge pclk);
      if (iss_ready === 1'b1) break;
      st++;
      if (st > 50) begin
        n_errors++;
        break;
      end
    end
  endtask

  task idle(input int n);
    iss_valid <= 1'b0;
    trap_take <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask

  initial begin
    #200000;
    n_errors++;
    print_verdict;
  end

  initial begin
    {presetn, psel, penable, pwrite, iss_valid, iss_imm_one} = 6'h00;
    trap_take = 1'b0;
    {paddr, iss_ra, iss_rb, iss_rc} = 32'h0;
    pwdata = 32'h0;
    iss_op = 4'h0;
    iss_imm = 16'h0;
    ops = '{`PHT_OP_LOAD, `PHT_OP_STORE, `PHT_OP_BRANCH, `PHT_OP_LOAD_MULTIPLE_INSTR,
      `PHT_OP_STORE_MULTIPLE_INSTR, `PHT_OP_INT};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, refusals, read back
    for (i = 0; i < 6; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 8'h18, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, `PHT_OFS_SP, 32'h55);
    chk(er, 1'b1);
    apb(1'b1, `PHT_OFS_ALU, 32'h5);
    apb(1'b0, `PHT_OFS_ALU, 32'h0);
    chk(rd, 32'h5);
    b = no;
    iss(`PHT_OP_INT, 8'h20, 8'h21, 16'h8001, 1'b0, 1'b0);
    iss(`PHT_OP_INT, 8'h20, 8'h21, 16'h8001, 1'b1, 1'b0);
    idle(2);
    chk(lg[b][34:3], 32'h00008001);
    chk(lg[b+1][34:3], 32'hFFFF8001);
    chk(out_carry_r, 32'h1);
    chk(out_byte_lane_r, 4'h4);
    chk(out_half_lane_r, 2'h2);
    apb(1'b1, `PHT_OFS_CFG, 32'h1);
    iss(`PHT_OP_INT, 8'h20, 8'h21, 16'h0, 1'b0, 1'b0);
    idle(2);
    chk(out_byte_lane_r, 4'h2);
    chk(out_half_lane_r, 2'h1);
    apb(1'b1, `PHT_OFS_CFG, 32'h0);
    b = no;
    iss(`PHT_OP_SETSP, 8'h22, 8'h22, 16'h0040, 1'b0, 1'b0);
    iss(`PHT_OP_INT, 8'h81, 8'h22, 16'h0, 1'b0, 1'b0);
    iss(`PHT_OP_INT, 8'h81, 8'h22, 16'h0, 1'b0, 1'b0);
    iss(`PHT_OP_SETSP, 8'h22, 8'h22, 16'h0080, 1'b0, 1'b1);
    iss(`PHT_OP_INT, 8'h81, 8'h22, 16'h0, 1'b0, 1'b0);
    idle(2);
    chk(lg[b+1][66:35], 32'h40);
    chk(lg[b+1][74:67], 8'h81);
    chk(lg[b+2][74:67], 8'h91);
    chk(lg[b+4][74:67], 8'hA1);
    // pointer reference right after a stack pointer write
    b = no;
    iss(`PHT_OP_SETIP, 8'h22, 8'h01, 16'h0055, 1'b0, 1'b0);
    iss(`PHT_OP_SETSP, 8'h22, 8'h22, 16'h0100, 1'b0, 1'b0);
    iss(`PHT_OP_INT, 8'h00, 8'h22, 16'h0, 1'b0, 1'b0);
    idle(2);
    chk(lg[b+2][74:67], 8'h55);
    b = no;
    iss(`PHT_OP_MTSR_PS, 8'h22, 8'h22, 16'h0002, 1'b0, 1'b0);
    for (i = 0; i < 6; i++) iss(ops[i], 8'h22, 8'h23, 16'h0, 1'b0, 1'b0);
    idle(2);
    chk(lg[b+1][2:1], 2'h0);
    chk(lg[b+2][2:1], 2'h2);
    for (i = 0; i < 6; i++) chk(lg[b+1+i][0], ops[i] != `PHT_OP_INT);
    // count is taken at start; a later change must not show
    apb(1'b1, `PHT_OFS_CHAN, 32'h7);
    iss(`PHT_OP_LOAD_MULTIPLE_INSTR, 8'h22, 8'h23, 16'h0, 1'b0, 1'b0);
    idle(2);
    apb(1'b1, `PHT_OFS_CHAN, 32'h3);
    chk(out_count_r, 8'h07);
    chk({out_op_r, out_abs_b_r, out_abs_c_r}, 20'hA2323);
    apb(1'b0, `PHT_OFS_REC, 32'h0);
    chk(rd, 32'h000023A2);
    iss(`PHT_OP_FADD, 8'h10, 8'h11, 16'h0, 1'b0, 1'b0);
    iss(`PHT_OP_FMUL, 8'h30, 8'h31, 16'h0, 1'b0, 1'b0);
    chk(st, 0);
    iss(`PHT_OP_INT, 8'h40, 8'h41, 16'h0, 1'b0, 1'b0);
    chk(st, 0);
    chk(fp_busy[1:0], 2'h3);
    iss(`PHT_OP_FADD, 8'h12, 8'h13, 16'h0, 1'b0, 1'b0);
    iss(`PHT_OP_FADD, 8'h14, 8'h15, 16'h0, 1'b0, 1'b0);
    chk(st > 0, 1'b1);
    iss(`PHT_OP_FDIV, 8'h60, 8'h61, 16'h0, 1'b0, 1'b0);
    iss(`PHT_OP_INT, 8'h61, 8'h60, 16'h0, 1'b0, 1'b0);
    chk(st > 0, 1'b1);
    idle(20);
    chk(dsn, 3'h7);
    chk(fp_busy, 3'h0);
    apb(1'b1, `PHT_OFS_CFG, 32'h2);
    @(posedge pclk);
    chk(intr_ok, 1'b0);
    apb(1'b1, `PHT_OFS_CFG, 32'h0);
    repeat (2) begin
      @(posedge pclk);
      chk(intr_ok, 1'b0);
    end
    @(posedge pclk);
    chk(intr_ok, 1'b1);
    print_verdict;
  end
endmodule // pht_core_bench

// ===== dv/pht_core_props.sv
// concurrent checks on the hazard control ports
`timescale 1ns/1ns
`include "pht_map.vh"
module pht_core_props #(
  parameter int ADD_LAT = 3
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pslverr,
  input wire iss_valid,
  input wire iss_ready,
  input wire [3:0] iss_op,
  input wire [15:0] iss_imm,
  input wire iss_imm_one,
  input wire out_valid_r,
  input wire [31:0] out_imm_r,
  input wire [31:0] out_gr1_r,
  input wire out_xlat_r,
  input wire [2:0] fp_done_r,
  input wire [2:0] fp_busy,
  input wire intr_ok
);
  localparam int LIM = ADD_LAT + 4;
  wire fire = iss_valid & iss_ready;
  wire xl = iss_op == `PHT_OP_LOAD || iss_op == `PHT_OP_STORE ||
    iss_op == `PHT_OP_BRANCH || iss_op == `PHT_OP_LOAD_MULTIPLE_INSTR ||
    iss_op == `PHT_OP_STORE_MULTIPLE_INSTR;
  wire acc = psel && penable && pwrite;
  // shadow of the freeze bit, from bus writes only
  reg frz_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frz_r <= 1'b0;
    end else if (acc && paddr == `PHT_OFS_CFG) begin
      frz_r <= pwdata[`PHT_CFG_FREEZE];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_sp_then;
    fire && iss_op == `PHT_OP_SETSP ##1 fire && iss_op != `PHT_OP_SETSP;
  endsequence
  sequence s_settle;
    !intr_ok ##1 !intr_ok;
  endsequence
  AST_SP_RO: assert property (acc && paddr == `PHT_OFS_SP |-> pslverr)
    else $error("write to stack pointer not refused");
  AST_OUTV: assert property (out_valid_r == $past(fire))
    else $error("result pulse not tied to issue");
  AST_IMMZ: assert property (fire && !iss_imm_one |=>
    out_imm_r == {16'h0000, $past(iss_imm)})
    else $error("zero-extended immediate wrong");
  AST_IMMO: assert property (fire && iss_imm_one |=>
    out_imm_r == {16'hFFFF, $past(iss_imm)})
    else $error("one-extended immediate wrong");
  AST_XLAT: assert property (fire |=> out_xlat_r == $past(xl))
    else $error("translation flag wrong");
  AST_UNIT: assert property (iss_valid && iss_op == `PHT_OP_FADD &&
    fp_busy[0] |-> !iss_ready)
    else $error("busy adder accepted another op");
  AST_DONE: assert property (fire && iss_op == `PHT_OP_FADD |->
    ##[1:LIM] fp_done_r[0])
    else $error("adder result late");
  AST_GR1: assert property (s_sp_then |=>
    out_gr1_r == $past(out_imm_r))
    else $error("stack pointer read not current");
  AST_FRZ: assert property ($fell(frz_r) |-> s_settle ##1 intr_ok)
    else $error("freeze settling not two cycles");
endmodule // pht_core_props
bind pht_core pht_core_props #(.ADD_LAT(ADD_LAT)) i_pht_core_props (.*);

// ===== hw/pht_core.v
// pipeline hazard and delayed-register control with apb registers
//
// Function
// RULE_01 - three fp units run beside integer work
// RULE_02 - independent instructions issue past pending fp
// RULE_03 - stall instruction needing unfinished fp result
// RULE_04 - stack pointer read sees write immediately
// RULE_05 - local register number offset by stack pointer
// RULE_06 - software leaves gap after stack pointer write
// RULE_07 - indirect access ignores stack pointer gap
// RULE_08 - software leaves gap after pointer write
// RULE_09 - trap makes new pointer values visible; code does so for the stack pointer only
// RULE_10 - software leaves gap after page-size write
// RULE_11 - branches, loads, stores translate addresses
// RULE_12 - freeze clear takes two cycles to settle
// RULE_13 - software waits two cycles before interrupts
// RULE_14 - zero-extended immediate fills upper zeros
// RULE_15 - one-extended immediate fills upper ones
// RULE_16 - carry widened with upper 31 zeros
// RULE_17 - byte pointer follows byte order setting
// RULE_18 - multiple transfer uses count captured at start
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ns
`include "pht_map.vh"
module pht_core #(
  parameter ADD_LAT = 3,
  parameter MUL_LAT = 3,
  parameter DIV_LAT = 11
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire iss_valid,
  output wire iss_ready,
  input wire [3:0] iss_op,
  input wire [7:0] iss_ra,
  input wire [7:0] iss_rb,
  input wire [7:0] iss_rc,
  input wire [15:0] iss_imm,
  input wire iss_imm_one,
  input wire trap_take,
  output reg out_valid_r,
  output reg [3:0] out_op_r,
  output reg [7:0] out_abs_a_r,
  output reg [7:0] out_abs_b_r,
  output reg [7:0] out_abs_c_r,
  output reg [31:0] out_imm_r,
  output reg [31:0] out_carry_r,
  output reg [3:0] out_byte_lane_r,
  output reg [1:0] out_half_lane_r,
  output reg [31:0] out_gr1_r,
  output reg out_xlat_r,
  output reg [1:0] out_ps_r,
  output reg [7:0] out_count_r,
  output reg [2:0] fp_done_r,
  output wire [2:0] fp_busy,
  output wire intr_ok
);
  reg [1:0] cfg_r;
  reg [7:0] alu_r;
  reg [7:0] chan_r;
  reg [31:0] sp_r;
  reg [31:0] sp_map_r;
  reg [7:0] ipa_r;
  reg [7:0] ipb_r;
  reg [7:0] ipc_r;
  reg [7:0] ipa_map_r;
  reg [7:0] ipb_map_r;
  reg [7:0] ipc_map_r;
  reg [1:0] ps_r;
  reg [1:0] ps_xlat_r;
  reg frz_prev_r;
  reg [1:0] settle_r;
  reg [15:0] rec_r;
  reg stall_seen_r;
  wire fire;
  wire hazard;
  wire structural;
  wire frz_eff;
  wire [7:0] abs_a;
  wire [7:0] abs_b;
  wire [7:0] abs_c;
  wire [31:0] imm_word;
  wire [31:0] carry_word;
  wire [3:0] byte_lane;
  wire [1:0] half_lane;
  wire [7:0] pend_add;
  wire [7:0] pend_mul;
  wire [7:0] pend_div;
  wire [2:0] fp_done;
  wire wr_en;
  wire rd_en;
  wire is_fp;
  wire is_xlat;
  wire is_multi;

  // register number 0 means "through the pointer", local when bit 7 set
  function [7:0] abs_reg;
    input [7:0] r;
    input [31:0] sp;
    input [7:0] ip;
    begin
      if (r == 8'h00) begin
        abs_reg = ip; // see RULE_07
      end else if (r[7]) begin
        abs_reg = {1'b1, r[6:0] + sp[8:2]}; // see RULE_05
      end else begin
        abs_reg = r;
      end
    end
  endfunction

  // local mapping reads the delayed copy; software keeps the gap
  assign abs_a = abs_reg(iss_ra, sp_map_r, ipa_map_r); // see RULE_06
  assign abs_b = abs_reg(iss_rb, sp_map_r, ipb_map_r);
  assign abs_c = abs_reg(iss_rc, sp_map_r, ipc_map_r); // see RULE_08

  pht_opnd u_opnd (
    .imm(iss_imm),
    .imm_one(iss_imm_one),
    .carry(alu_r[`PHT_ALU_CARRY]),
    .bp(alu_r[`PHT_ALU_BP_HI:`PHT_ALU_BP_LO]),
    .big_endian(cfg_r[`PHT_CFG_BORDER]),
    .imm_word(imm_word),
    .carry_word(carry_word),
    .byte_lane(byte_lane),
    .half_lane(half_lane)
  );

  // the three units are independent; none waits on another
  pht_fp_pipe #(.LAT(ADD_LAT)) u_fadd (
    .pclk(pclk),
    .presetn(presetn),
    .start(fire && iss_op == `PHT_OP_FADD), // see RULE_01
    .dest(abs_c),
    .busy(fp_busy[0]),
    .pend_dest_r(pend_add),
    .done_r(fp_done[0])
  );
  pht_fp_pipe #(.LAT(MUL_LAT)) u_fmul (
    .pclk(pclk),
    .presetn(presetn),
    .start(fire && iss_op == `PHT_OP_FMUL), // see RULE_01
    .dest(abs_c),
    .busy(fp_busy[1]),
    .pend_dest_r(pend_mul),
    .done_r(fp_done[1])
  );
  pht_fp_pipe #(.LAT(DIV_LAT)) u_fdiv (
    .pclk(pclk),
    .presetn(presetn),
    .start(fire && iss_op == `PHT_OP_FDIV), // see RULE_01
    .dest(abs_c),
    .busy(fp_busy[2]),
    .pend_dest_r(pend_div),
    .done_r(fp_done[2])
  );

  // does the instruction touch a register an fp unit still owes?
  function dep;
    input bsy;
    input [7:0] pd;
    input [7:0] a;
    input [7:0] b;
    input [7:0] c;
    begin
      dep = bsy && (pd == a || pd == b || pd == c);
    end
  endfunction

  assign hazard = dep(fp_busy[0], pend_add, abs_a, abs_b, abs_c) ||
                  dep(fp_busy[1], pend_mul, abs_a, abs_b, abs_c) ||
                  dep(fp_busy[2], pend_div, abs_a, abs_b, abs_c); // see RULE_03
  // a unit takes one operation at a time, so a second one waits
  assign structural = (iss_op == `PHT_OP_FADD && fp_busy[0]) ||
                      (iss_op == `PHT_OP_FMUL && fp_busy[1]) ||
                      (iss_op == `PHT_OP_FDIV && fp_busy[2]);
  // dependents and ops for a busy unit wait; everything else flows past the fp units
  assign iss_ready = !hazard && !structural; // see RULE_02
  assign fire = iss_valid && iss_ready;

  assign is_fp = (iss_op == `PHT_OP_FADD) || (iss_op == `PHT_OP_FMUL) ||
                 (iss_op == `PHT_OP_FDIV);
  assign is_xlat = (iss_op == `PHT_OP_LOAD) || (iss_op == `PHT_OP_STORE) ||
                   (iss_op == `PHT_OP_BRANCH) ||
                   (iss_op == `PHT_OP_LOAD_MULTIPLE_INSTR) ||
                   (iss_op == `PHT_OP_STORE_MULTIPLE_INSTR); // see RULE_11
  assign is_multi = (iss_op == `PHT_OP_LOAD_MULTIPLE_INSTR) ||
                    (iss_op == `PHT_OP_STORE_MULTIPLE_INSTR);

  // stack pointer, indirect pointers and page size
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_r <= `PHT_SP_RST;
      sp_map_r <= `PHT_SP_RST;
      ipa_r <= 8'h00;
      ipb_r <= 8'h00;
      ipc_r <= 8'h00;
      ipa_map_r <= 8'h00;
      ipb_map_r <= 8'h00;
      ipc_map_r <= 8'h00;
      ps_r <= 2'h0;
      ps_xlat_r <= 2'h0;
    end else begin
      if (fire && iss_op == `PHT_OP_SETSP) begin
        sp_r <= imm_word;
      end
      if (fire && iss_op == `PHT_OP_SETIP) begin
        if (iss_rc[1:0] == 2'h1) begin
          ipa_r <= imm_word[7:0];
        end else if (iss_rc[1:0] == 2'h2) begin
          ipb_r <= imm_word[7:0];
        end else if (iss_rc[1:0] == 2'h3) begin
          ipc_r <= imm_word[7:0];
        end
      end
      if (fire && iss_op == `PHT_OP_MTSR_PS) begin
        ps_r <= imm_word[1:0];
      end
      // copies trail by one cycle; a trap hands the stack pointer over live
      if (trap_take) begin
        sp_map_r <= (fire && iss_op == `PHT_OP_SETSP) ? imm_word
                                                      : sp_r; // see RULE_09
        ipa_map_r <= ipa_r;
        ipb_map_r <= ipb_r;
        ipc_map_r <= ipc_r;
        ps_xlat_r <= ps_r;
      end else begin
        sp_map_r <= sp_r;
        ipa_map_r <= ipa_r;
        ipb_map_r <= ipb_r;
        ipc_map_r <= ipc_r;
        ps_xlat_r <= ps_r; // see RULE_10
      end
    end
  end

  // freeze settling: governed state resumes two cycles after clear
  // the delayed copy covers the cycle before the settle count loads
  assign frz_eff = cfg_r[`PHT_CFG_FREEZE] || frz_prev_r ||
                   (settle_r != 2'h0);
  assign intr_ok = !frz_eff; // see RULE_13
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frz_prev_r <= 1'b0;
      settle_r <= 2'h0;
      rec_r <= 16'h0000;
    end else begin
      frz_prev_r <= cfg_r[`PHT_CFG_FREEZE];
      if (frz_prev_r && !cfg_r[`PHT_CFG_FREEZE]) begin
        settle_r <= `PHT_FZ_SETTLE - 2'h1; // see RULE_12
      end else if (settle_r != 2'h0) begin
        settle_r <= settle_r - 2'h1;
      end
      if (fire && is_xlat && !frz_eff) begin
        rec_r <= {abs_c, iss_op, 2'h0, ps_xlat_r}; // see RULE_12
      end
    end
  end

  // issued instruction record
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid_r <= 1'b0;
      out_op_r <= `PHT_OP_INT;
      out_abs_a_r <= 8'h00;
      out_abs_b_r <= 8'h00;
      out_abs_c_r <= 8'h00;
      out_imm_r <= 32'h00000000;
      out_carry_r <= 32'h00000000;
      out_byte_lane_r <= 4'h0;
      out_half_lane_r <= 2'h0;
      out_gr1_r <= `PHT_SP_RST;
      out_xlat_r <= 1'b0;
      out_ps_r <= 2'h0;
      out_count_r <= 8'h00;
      fp_done_r <= 3'h0;
      stall_seen_r <= 1'b0;
    end else begin
      out_valid_r <= fire;
      fp_done_r <= fp_done;
      if (iss_valid && !iss_ready) begin
        stall_seen_r <= 1'b1;
      end else if (wr_en && paddr == `PHT_OFS_STAT) begin
        stall_seen_r <= 1'b0;
      end
      out_xlat_r <= fire && is_xlat;
      if (fire) begin
        out_op_r <= iss_op;
        out_abs_a_r <= abs_a;
        out_abs_b_r <= abs_b;
        out_abs_c_r <= abs_c;
        out_imm_r <= imm_word; // see RULE_14 RULE_15
        out_carry_r <= carry_word; // see RULE_16
        out_byte_lane_r <= byte_lane; // see RULE_17
        out_half_lane_r <= half_lane;
        out_ps_r <= ps_xlat_r; // see RULE_11
        // gr1 read right after a write gets the new value
        if (iss_op == `PHT_OP_SETSP) begin
          out_gr1_r <= imm_word;
        end else begin
          out_gr1_r <= sp_r; // see RULE_04
        end
        if (is_multi) begin
          out_count_r <= chan_r; // see RULE_18
        end
      end
    end
  end

  // apb slave, zero wait states
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !pwrite;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= `PHT_CFG_RST;
      alu_r <= `PHT_ALU_RST;
      chan_r <= `PHT_CHAN_RST;
    end else if (wr_en) begin
      if (paddr == `PHT_OFS_CFG) begin
        cfg_r <= pwdata[1:0];
      end else if (paddr == `PHT_OFS_ALU) begin
        alu_r <= pwdata[7:0];
      end else if (paddr == `PHT_OFS_CHAN) begin
        chan_r <= pwdata[7:0];
      end
    end
  end

  always @* begin
    pslverr = 1'b0;
    prdata = 32'h00000000;
    if (psel && penable) begin
      if (paddr == `PHT_OFS_CFG) begin
        prdata = {30'h00000000, cfg_r};
      end else if (paddr == `PHT_OFS_ALU) begin
        prdata = {24'h000000, alu_r};
      end else if (paddr == `PHT_OFS_CHAN) begin
        prdata = {24'h000000, chan_r};
      end else if (paddr == `PHT_OFS_STAT) begin
        prdata = {23'h000000, ps_xlat_r, ps_r, frz_eff, stall_seen_r,
                  fp_busy};
      end else if (paddr == `PHT_OFS_SP) begin
        if (rd_en) begin
          prdata = sp_r;
        end else begin
          pslverr = 1'b1;
        end
      end else if (paddr == `PHT_OFS_REC) begin
        prdata = {16'h0000, rec_r};
      end else begin
        pslverr = 1'b1;
      end
    end
  end
endmodule // pht_core

// ===== hw/pht_fp_pipe.v
// one floating-point unit: fixed latency, one operation in flight
`timescale 1ns/1ns
module pht_fp_pipe #(
  parameter LAT = 3
) (
  input wire pclk,
  input wire presetn,
  input wire start,
  input wire [7:0] dest,
  output wire busy,
  output reg [7:0] pend_dest_r,
  output reg done_r
);
  reg [7:0] cnt_r;
  assign busy = (cnt_r != 8'h00);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
      pend_dest_r <= 8'h00;
      done_r <= 1'b0;
    end else begin
      done_r <= (cnt_r == 8'h01);
      if (start && !busy) begin
        cnt_r <= LAT[7:0];
        pend_dest_r <= dest;
      end else if (busy) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule // pht_fp_pipe

// ===== hw/pht_map.vh
// register map, field positions, reset values and timing counts
`ifndef PHT_MAP_VH
`define PHT_MAP_VH
`define PHT_OFS_CFG 8'h00
`define PHT_OFS_ALU 8'h04
`define PHT_OFS_CHAN 8'h08
`define PHT_OFS_STAT 8'h0C
`define PHT_OFS_SP 8'h10
`define PHT_OFS_REC 8'h14
`define PHT_CFG_BORDER 0
`define PHT_CFG_FREEZE 1
`define PHT_ALU_CARRY 0
`define PHT_ALU_BP_LO 1
`define PHT_ALU_BP_HI 2
`define PHT_ALU_FSA_LO 3
`define PHT_ALU_FSA_HI 7
`define PHT_CFG_RST 2'h0
`define PHT_ALU_RST 8'h00
`define PHT_CHAN_RST 8'h00
`define PHT_SP_RST 32'h00000000
`define PHT_FZ_SETTLE 2'h2
`define PHT_OP_INT 4'h0
`define PHT_OP_FADD 4'h1
`define PHT_OP_FMUL 4'h2
`define PHT_OP_FDIV 4'h3
`define PHT_OP_LOAD 4'h4
`define PHT_OP_STORE 4'h5
`define PHT_OP_BRANCH 4'h6
`define PHT_OP_SETSP 4'h7
`define PHT_OP_SETIP 4'h8
`define PHT_OP_MTSR_PS 4'h9
`define PHT_OP_LOAD_MULTIPLE_INSTR 4'hA
`define PHT_OP_STORE_MULTIPLE_INSTR 4'hB
`define PHT_GR_SP 8'h01
`endif

// ===== hw/pht_opnd.v
// operand former: immediate, carry and byte-pointer widening
`timescale 1ns/1ns
module pht_opnd (
  input wire [15:0] imm,
  input wire imm_one,
  input wire carry,
  input wire [1:0] bp,
  input wire big_endian,
  output wire [31:0] imm_word,
  output wire [31:0] carry_word,
  output wire [3:0] byte_lane,
  output wire [1:0] half_lane
);
  // upper half all ones or all zeros, never sign extension
  assign imm_word = imm_one ? {16'hFFFF, imm} : {16'h0000, imm}; // see RULE_14 RULE_15
  assign carry_word = {31'h00000000, carry}; // see RULE_16
  // byte 0 is the most significant lane when big-endian
  wire [1:0] lane = big_endian ? ~bp : bp; // see RULE_17
  assign byte_lane = 4'h1 << lane;
  assign half_lane = big_endian ? {~bp[1], bp[1]} : {bp[1], ~bp[1]};
endmodule // pht_opnd
